// [test/card_session_chk.sv]
// Link checker for the card session interface.
`timescale 1ns/10ps
`default_nettype none
module card_session_chk
	import card_session_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Link
	input wire logic vcc_on,
	input wire logic rst_pin_n,
	input wire logic clk_run,
	input wire logic t2c_stb,
	input wire logic [7:0] t2c_dat,
	input wire logic t2c_par,
	input wire logic c2t_stb,
	input wire logic [7:0] c2t_dat,
	input wire logic c2t_par
);
	logic p_reg;
	logic r_reg;
	logic [10:0] i_reg;
	logic [9:0] n_reg;
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	always_ff @(posedge mclk)
	begin
		p_reg <= reset_n && (!rst_pin_n || (p_reg && !c2t_stb));
		r_reg <= reset_n && vcc_on && (r_reg || $fell(clk_run));
		i_reg <= (!reset_n || c2t_stb) ? 11'h000 : i_reg + {10'h000, i_reg != 11'h7FF};
		n_reg <= (!reset_n || !clk_run) ? 10'h000 : n_reg + {9'h000, n_reg != 10'h3FF};
	end
	a_t2c_parity: assert property (t2c_stb |-> t2c_par == ^t2c_dat) else $error("t2c parity");
	a_c2t_parity: assert property (c2t_stb |-> c2t_par == ^c2t_dat) else $error("c2t parity");
	a_card_gap: assert property (c2t_stb |=> !c2t_stb [*3]) else $error("c2t gap");
	a_vcc_cold: assert property ($rose(vcc_on) |-> !rst_pin_n) else $error("cold reset");
	a_reset_quiet: assert property (!rst_pin_n [*3] |-> !c2t_stb) else $error("talk in reset");
	a_first_ts: assert property (c2t_stb && p_reg |-> c2t_dat == TS_DIRECT) else $error("first byte");
	a_atr_first: assert property (t2c_stb |-> !p_reg) else $error("early command");
	a_stop_idle: assert property ($fell(clk_run) && vcc_on |-> i_reg >= CLK_STOP_WAIT) else $error("stop");
	a_restart_wait: assert property (t2c_stb && r_reg |-> n_reg >= CLK_RESTART_WAIT) else $error("restart");
	cover property ($fell(clk_run) && vcc_on);
	cover property (c2t_stb && p_reg);
	cover property (t2c_stb && r_reg);
endmodule
`default_nettype wire

// [test/card_session_control_tb_top.sv]
// Bench joining terminal and card ends of the session link.
`timescale 1ns/10ps
`default_nettype none
module card_session_control_tb_top
	import card_session_pkg::*;
;
	logic mclk, reset_n, wr, rd, tx_stb, sec_grant, rx_stb, tx_ready, secure, specific, session;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, rdata2, tx_byte, rx_byte, fd, rxl, s, s2;
	logic [3:0] proto;
	logic [7:0] atr[14];
	logic [7:0] a0[14];
	int errors = 0;
	int n_tests = 0;
	int ai = 0;
	int cyc = 0;
	card_link_if lk();
	card_link_if lk2();
	assign {lk2.c2t_stb, lk2.c2t_dat, lk2.c2t_par, lk2.c2t_nak} = 11'h000;
	term_end #(.RST_HOLD(4), .ATR_TMO(200)) term_end_inst (.mclk, .reset_n, .addr, .wdata, .wr, .rd, .rdata,
		.lk(lk.term));
	term_end #(.RST_HOLD(4), .ATR_TMO(200)) term_end_inst2 (.mclk, .reset_n, .addr, .wdata, .wr, .rd,
		.rdata(rdata2), .lk(lk2.term));
	card_end card_end_inst (.mclk, .reset_n, .lk(lk.card), .rx_stb, .rx_byte, .tx_stb, .tx_byte, .tx_ready,
		.sec_grant, .secure, .specific, .session, .fd, .proto);
	card_session_chk card_session_chk_inst (.mclk, .reset_n, .vcc_on(lk.vcc_on), .rst_pin_n(lk.rst_pin_n),
		.clk_run(lk.clk_run), .t2c_stb(lk.t2c_stb), .t2c_dat(lk.t2c_dat), .t2c_par(lk.t2c_par),
		.c2t_stb(lk.c2t_stb), .c2t_dat(lk.c2t_dat), .c2t_par(lk.c2t_par));
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		ai <= !lk.rst_pin_n ? 0 : ai + {31'h0, lk.c2t_stb};
		if (lk.c2t_stb && ai < 14)
			atr[ai] <= lk.c2t_dat;
		if (rx_stb)
			rxl <= rx_byte;
		if (cyc == 40000)
		begin
			errors++;
			final_report();
		end
	end
	task final_report();
		if (errors == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e)
		begin
			errors++;
			$display("Error %0t: got %h want %h", $time, g, e);
		end
	endtask
	task wreg(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task rreg(input logic [2:0] a);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 s = rdata;
		s2 = rdata2;
	endtask
	task waitb(input int b, input logic v);
		for (int k = 0; k < 4000; k++)
		begin
			rreg(REG_STATUS);
			if (s[b] === v)
				break;
		end
		chk({7'h00, s[b]}, {7'h00, v});
	endtask
	task t_atr();
		wreg(REG_CTRL, 8'h11);
		waitb(0, 1'b1);
		chk(atr[0], TS_DIRECT);
		chk(atr[2], 8'h95);
		chk(atr[4], 8'h1F);
		chk(atr[5], 8'h46);
		chk(atr[6], CAT_COMPACT);
		chk(atr[7], TAG_DATA_SERVICE);
		chk(atr[9], TAG_CAPABILITIES);
		chk({7'h00, secure}, 8'h00);
		chk(fd, FD_DEFAULT);
		a0 = atr;
	endtask
	task t_warm();
		for (int k = 0; k < 2; k++)
		begin
			@(posedge mclk);
			sec_grant <= 1'b1;
			@(posedge mclk);
			sec_grant <= 1'b0;
			wreg(REG_PPS_REQ, k ? FD_512_16 : FD_512_8);
			if (k)
				chk({7'h00, secure}, 8'h01);
			wreg(REG_CTRL, 8'h17);
			waitb(0, 1'b0);
			waitb(0, 1'b1);
			repeat (4) @(posedge mclk);
			chk(fd, k ? FD_512_16 : FD_512_8);
			chk({7'h00, secure}, 8'h00);
			chk({7'h00, specific}, 8'h00);
			for (int i = 0; i < 14; i++)
				chk(atr[i], a0[i]);
		end
	endtask
	task t_cmd(input logic [7:0] c, input logic [7:0] r);
		wreg(REG_DATA, c);
		for (int k = 0; k < 200 && (rxl !== c || tx_ready !== 1'b1); k++)
			@(posedge mclk);
		chk(rxl, c);
		tx_byte <= r;
		tx_stb <= 1'b1;
		@(posedge mclk);
		tx_stb <= 1'b0;
		waitb(1, 1'b1);
		rreg(REG_DATA);
		chk(s, r);
	endtask
	task t_stop();
		wreg(REG_CTRL, 8'h0D);
		waitb(3, 1'b1);
		chk({6'h00, s[6], lk.clk_run}, 8'h02);
		wreg(REG_CTRL, 8'h05);
		waitb(3, 1'b0);
		waitb(0, 1'b1);
	endtask
	task t_reject();
		rreg(REG_BAD);
		chk(s2, 8'h03);
		chk(s, 8'h00);
		rreg(REG_STATUS);
		chk({6'h00, s2[2], lk2.vcc_on}, 8'h02);
		rreg(3'h7);
		chk(s, 8'h00);
	endtask
	initial
	begin
		{wr, rd, tx_stb, sec_grant, addr, wdata, tx_byte, reset_n} = 24'h0;
		repeat (3) @(posedge mclk);
		reset_n <= 1'b1;
		t_atr();
		t_warm();
		t_cmd(8'hA5, 8'h5A);
		t_stop();
		t_cmd(8'h3C, 8'hC3);
		t_reject();
		final_report();
	end
endmodule
`default_nettype wire

// [verilog/card_end.sv]
// Card end of the session link: answer to reset, speed negotiation, reset modes and security status.
//
// Operation
// - First historical byte is category 80.
// - First data object is data service, tag 31.
// - Second data object is capabilities, tag 73.
// - Support factor pairs 512/8, 512/16, 372/1.
// - Advertise clock and baud factors in TA1.
// - Negotiate before non-default factors; stay in range.
// - Cold reset: negotiable mode, clear security status.
// - Warm specific mode keeps protocol and factors.
// - Identical answer after every warm reset.
// - Warm reset clears security status.
// - Clock stop shown in T=15 TA3.
// - Terminal obeys the card's clock stop indication.
// - Terminal waits 1860 cycles before stopping clock.
// - Terminal waits 744 cycles after clock restart.
// - Terminal resets on bad answer, rejects after three.
// - Terminal error repetition mandatory after the answer.
// - Card always repeats characters in T=0.
// - Terminal has both protocols, card at least one.
// - Protocol starts after answer or successful negotiation.
// - Answer to reset is first after each reset.
// - Answer carries T=15 global parameters.
`timescale 1ns/10ps
`default_nettype none
module card_end
	import card_session_pkg::*;
#(
	parameter logic [7:0] FD_ADV = 8'h95,
	parameter logic [1:0] PROTO_SET = 2'b01,
	parameter logic [5:0] CLASS_IND = 6'h06,
	parameter logic [1:0] CLKSTOP = 2'h1,
	parameter bit WARM_SPECIFIC = 1'b0,
	parameter logic [7:0] SERVICE_DATA = 8'hA0,
	parameter logic [23:0] CAP_DATA = 24'h000000
)(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Link
	card_link_if.card lk,
	// Received command bytes
	output logic rx_stb,
	output logic [7:0] rx_byte,
	// Response bytes
	input wire logic tx_stb,
	input wire logic [7:0] tx_byte,
	output logic tx_ready,
	// Session state
	input wire logic sec_grant,
	output logic secure,
	output logic specific,
	output logic session,
	output logic [7:0] fd,
	output logic [3:0] proto
);
	if (PROTO_SET == 2'b00) $error("The card needs at least one protocol.");
	if (CLASS_IND != 6'h01 && CLKSTOP == 2'h0) $error("Clock stop must be allowed beyond class A.");
	if (FD_ADV[7:4] < FD_512_16[7:4] || FD_ADV[3:0] < FD_512_16[3:0]) $error("FD_ADV below 512/16.");
	localparam logic [3:0] PROTO_FIRST = PROTO_SET[0] ? PROTO_T0 : 4'h1;
	typedef enum logic [2:0] {C_OFF, C_RST, C_ATR, C_NEG, C_PPS, C_ECHO, C_SESS} cstate_t;
	typedef struct packed {
		cstate_t st;
		logic warm;
		logic specific;
		logic [7:0] fd;
		logic [3:0] proto;
		logic secure;
		logic session;
		logic [3:0] idx;
		logic go;
		logic [7:0] go_byte;
		logic [3:0][7:0] pps;
		logic [2:0] pps_n;
		logic rx_stb;
		logic [7:0] rx_byte;
		logic tx_ready;
	} card_t;
	card_t s_reg, s_next;
	logic tx_busy;
	logic rx_ok;
	logic [7:0] rx_dat;
	// Fixed answer bytes, before the check byte.
	function automatic logic [7:0] atr_raw(input logic [3:0] i);
		logic [7:0] r;
		r = 8'h00;
		unique case (i)
			4'h0: r = TS_DIRECT;
			4'h1: r = {Y_TA_TD, HIST_LEN};
			4'h2: r = FD_ADV;
			4'h3: r = {Y_TD, PROTO_FIRST};
			4'h4: r = {Y_TA, PROTO_T15};
			4'h5: r = {CLKSTOP, CLASS_IND};
			4'h6: r = CAT_COMPACT;
			4'h7: r = TAG_DATA_SERVICE;
			4'h8: r = SERVICE_DATA;
			4'h9: r = TAG_CAPABILITIES;
			4'hA: r = CAP_DATA[23:16];
			4'hB: r = CAP_DATA[15:8];
			4'hC: r = CAP_DATA[7:0];
			default: r = 8'h00;
		endcase
		return r;
	endfunction
	// The whole answer depends on parameters only, so every reset sends the same bytes.
	function automatic logic [7:0] atr_byte(input logic [3:0] i);
		logic [7:0] x;
		x = 8'h00;
		for (int j = 1; j < 13; j++)
			x = x ^ atr_raw(4'(j));
		return (i == ATR_LEN - 4'h1) ? x : atr_raw(i);
	endfunction
	function automatic logic fd_ok(input logic [7:0] v);
		logic pair;
		pair = (v == FD_DEFAULT) || (v == FD_512_8) || (v == FD_512_16);
		return pair && v[7:4] <= FD_ADV[7:4] && v[3:0] <= FD_ADV[3:0];
	endfunction
	always_comb
	begin
		logic [2:0] nn;
		logic [2:0] len;
		logic [7:0] sum;
		logic [7:0] req_fd;
		nn = 3'h0;
		len = 3'h3;
		sum = 8'h00;
		req_fd = FD_DEFAULT;
		s_next = s_reg;
		s_next.go = 1'b0;
		s_next.rx_stb = 1'b0;
		if (!lk.vcc_on)
		begin
			s_next.st = C_OFF;
			s_next.warm = 1'b0;
			s_next.secure = 1'b0;
			s_next.session = 1'b0;
		end
		else if (!lk.rst_pin_n)
		begin
			s_next.st = C_RST;
			s_next.secure = 1'b0;
			s_next.session = 1'b0;
		end
		else if (lk.clk_run)
		begin
			unique case (s_reg.st)
				C_OFF: ;
				C_RST:
				begin
					s_next.st = C_ATR;
					s_next.idx = 4'h0;
					s_next.warm = 1'b1;
					if (s_reg.warm && WARM_SPECIFIC)
						s_next.specific = 1'b1;
					else
					begin
						s_next.specific = 1'b0;
						s_next.fd = FD_DEFAULT;
						s_next.proto = PROTO_FIRST;
					end
				end
				C_ATR:
				begin
					if (!tx_busy && !s_reg.go)
					begin
						if (s_reg.idx == ATR_LEN)
						begin
							s_next.st = s_reg.specific ? C_SESS : C_NEG;
							s_next.session = s_reg.specific;
						end
						else
						begin
							s_next.go = 1'b1;
							s_next.go_byte = atr_byte(s_reg.idx);
							s_next.idx = s_reg.idx + 4'h1;
						end
					end
				end
				C_NEG:
				begin
					if (rx_ok && rx_dat == PPS_START)
					begin
						s_next.st = C_PPS;
						s_next.pps[0] = rx_dat;
						s_next.pps_n = 3'h1;
					end
					else if (rx_ok)
					begin
						s_next.st = C_SESS;
						s_next.session = 1'b1;
						s_next.rx_stb = 1'b1;
						s_next.rx_byte = rx_dat;
					end
				end
				C_PPS:
				begin
					if (rx_ok)
					begin
						s_next.pps[s_reg.pps_n[1:0]] = rx_dat;
						nn = s_reg.pps_n + 3'h1;
						s_next.pps_n = nn;
						len = (nn >= 3'h2 && s_next.pps[1][4]) ? 3'h4 : 3'h3;
						if (nn == len)
						begin
							for (int j = 0; j < 4; j++)
								if (3'(j) < len)
									sum = sum ^ s_next.pps[j];
							if (len == 3'h4)
								req_fd = s_next.pps[2];
							s_next.idx = 4'h0;
							if (sum == 8'h00 && fd_ok(req_fd) && s_next.pps[1][3:2] == 2'h0
								&& PROTO_SET[s_next.pps[1][0]] && s_next.pps[1][1] == 1'b0)
								s_next.st = C_ECHO;
							else
								s_next.st = C_NEG;
						end
					end
				end
				C_ECHO:
				begin
					len = s_reg.pps[1][4] ? 3'h4 : 3'h3;
					if (!tx_busy && !s_reg.go)
					begin
						if (s_reg.idx[2:0] == len)
						begin
							s_next.fd = s_reg.pps[1][4] ? s_reg.pps[2] : FD_DEFAULT;
							s_next.proto = s_reg.pps[1][3:0];
							s_next.st = C_SESS;
							s_next.session = 1'b1;
						end
						else
						begin
							s_next.go = 1'b1;
							s_next.go_byte = s_reg.pps[s_reg.idx[1:0]];
							s_next.idx = s_reg.idx + 4'h1;
						end
					end
				end
				C_SESS:
				begin
					if (rx_ok)
					begin
						s_next.rx_stb = 1'b1;
						s_next.rx_byte = rx_dat;
					end
					if (tx_stb && s_reg.tx_ready)
					begin
						s_next.go = 1'b1;
						s_next.go_byte = tx_byte;
					end
					if (sec_grant)
						s_next.secure = 1'b1;
				end
				default: s_next.st = C_OFF;
			endcase
		end
		s_next.tx_ready = s_next.st == C_SESS && !tx_busy && !s_next.go && !s_reg.go;
	end
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			s_reg <= '0;
			s_reg.st <= C_OFF;
			s_reg.fd <= FD_DEFAULT;
		end
		else
			s_reg <= s_next;
	end
	char_port #(
		.MAX_REPEAT(4)
	) u_port (
		.mclk(mclk),
		.reset_n(reset_n),
		.chk_en(s_reg.proto == PROTO_T0),
		.tx_go(s_reg.go),
		.tx_byte(s_reg.go_byte),
		.tx_busy(tx_busy),
		.tx_fail(),
		.rx_ok(rx_ok),
		.rx_byte(rx_dat),
		.stb(lk.c2t_stb),
		.dat(lk.c2t_dat),
		.par(lk.c2t_par),
		.nak(lk.c2t_nak),
		.peer_stb(lk.t2c_stb),
		.peer_dat(lk.t2c_dat),
		.peer_par(lk.t2c_par),
		.peer_nak(lk.t2c_nak)
	);
	assign rx_stb = s_reg.rx_stb;
	assign rx_byte = s_reg.rx_byte;
	assign tx_ready = s_reg.tx_ready;
	assign secure = s_reg.secure;
	assign specific = s_reg.specific;
	assign session = s_reg.session;
	assign fd = s_reg.fd;
	assign proto = s_reg.proto;
endmodule
`default_nettype wire

// [verilog/card_link_if.sv]
// Character-level link between terminal and card: power, reset pin, clock run and both data directions.
`timescale 1ns/10ps
`default_nettype none
interface card_link_if;
	logic vcc_on;
	logic rst_pin_n;
	logic clk_run;
	logic t2c_stb;
	logic [7:0] t2c_dat;
	logic t2c_par;
	logic t2c_nak;
	logic c2t_stb;
	logic [7:0] c2t_dat;
	logic c2t_par;
	logic c2t_nak;
	modport card (input vcc_on, rst_pin_n, clk_run, t2c_stb, t2c_dat, t2c_par, t2c_nak,
		output c2t_stb, c2t_dat, c2t_par, c2t_nak);
	modport term (output vcc_on, rst_pin_n, clk_run, t2c_stb, t2c_dat, t2c_par, t2c_nak,
		input c2t_stb, c2t_dat, c2t_par, c2t_nak);
endinterface
`default_nettype wire

// [verilog/card_session_pkg.sv]
// Shared constants for the card session link: answer-to-reset codes, timing and register map.
`default_nettype none
package card_session_pkg;
	// Answer-to-reset and negotiation codes.
	localparam logic [7:0] TS_DIRECT = 8'h3B;
	localparam logic [7:0] TS_INVERSE = 8'h3F;
	localparam logic [7:0] CAT_COMPACT = 8'h80;
	localparam logic [7:0] TAG_DATA_SERVICE = 8'h31;
	localparam logic [7:0] TAG_CAPABILITIES = 8'h73;
	localparam logic [7:0] PPS_START = 8'hFF;
	localparam logic [7:0] PPS0_WITH_PPS1 = 8'h10;
	localparam logic [7:0] FD_DEFAULT = 8'h11;
	localparam logic [7:0] FD_512_8 = 8'h94;
	localparam logic [7:0] FD_512_16 = 8'h95;
	localparam logic [3:0] Y_TA_TD = 4'h9;
	localparam logic [3:0] Y_TD = 4'h8;
	localparam logic [3:0] Y_TA = 4'h1;
	localparam logic [3:0] PROTO_T0 = 4'h0;
	localparam logic [3:0] PROTO_T15 = 4'hF;
	localparam logic [3:0] ATR_LEN = 4'hE;
	localparam logic [3:0] HIST_LEN = 4'h7;
	// Timing in card clock cycles and the bad answer limit; the card clock runs at the mclk rate.
	localparam int CLK_STOP_WAIT = 1860;
	localparam int CLK_RESTART_WAIT = 744;
	localparam logic [1:0] NAK_WAIT = 2'h2;
	localparam logic [1:0] BAD_ATR_LIMIT = 2'h3;
	// Controller register map.
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_PPS_REQ = 3'h1;
	localparam logic [2:0] REG_DATA = 3'h2;
	localparam logic [2:0] REG_STATUS = 3'h3;
	localparam logic [2:0] REG_TA1 = 3'h4;
	localparam logic [2:0] REG_BAD = 3'h5;
	localparam int CTRL_ACT = 0;
	localparam int CTRL_WARM = 1;
	localparam int CTRL_PPS = 2;
	localparam int CTRL_STOP = 3;
	localparam int CTRL_ATRCHK = 4;
	localparam logic [4:0] CTRL_RESET = 5'h00;
	localparam logic [7:0] PPS_REQ_RESET = 8'h11;
endpackage
`default_nettype wire

// [verilog/char_port.sv]
// Character sender and receiver with parity check and repetition on a reported error.
`timescale 1ns/10ps
`default_nettype none
module char_port
	import card_session_pkg::*;
#(
	parameter int MAX_REPEAT = 4
)(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// User side
	input wire logic chk_en,
	input wire logic tx_go,
	input wire logic [7:0] tx_byte,
	output logic tx_busy,
	output logic tx_fail,
	output logic rx_ok,
	output logic [7:0] rx_byte,
	// Line side
	output logic stb,
	output logic [7:0] dat,
	output logic par,
	output logic nak,
	input wire logic peer_stb,
	input wire logic [7:0] peer_dat,
	input wire logic peer_par,
	input wire logic peer_nak
);
	if (MAX_REPEAT < 1 || MAX_REPEAT > 7) $error("MAX_REPEAT must be 1 to 7.");
	typedef struct packed {
		logic busy;
		logic [1:0] wait_cnt;
		logic [2:0] reps;
		logic fail;
		logic stb;
		logic [7:0] dat;
		logic par;
		logic nak;
		logic rx_ok;
		logic [7:0] rx_byte;
	} port_t;
	port_t s_reg, s_next;
	always_comb
	begin
		s_next = s_reg;
		s_next.stb = 1'b0;
		s_next.nak = 1'b0;
		s_next.rx_ok = 1'b0;
		s_next.fail = 1'b0;
		if (s_reg.busy)
		begin
			if (peer_nak)
			begin
				if (s_reg.reps == 3'(MAX_REPEAT))
				begin
					s_next.busy = 1'b0;
					s_next.fail = 1'b1;
				end
				else
				begin
					s_next.stb = 1'b1;
					s_next.reps = s_reg.reps + 3'h1;
					s_next.wait_cnt = NAK_WAIT;
				end
			end
			else if (s_reg.wait_cnt == 2'h0)
				s_next.busy = 1'b0;
			else
				s_next.wait_cnt = s_reg.wait_cnt - 2'h1;
		end
		else if (tx_go)
		begin
			s_next.busy = 1'b1;
			s_next.stb = 1'b1;
			s_next.dat = tx_byte;
			s_next.par = ^tx_byte;
			s_next.reps = 3'h0;
			s_next.wait_cnt = NAK_WAIT;
		end
		if (peer_stb)
		begin
			if (chk_en && ((^peer_dat) != peer_par))
				s_next.nak = 1'b1;
			else
			begin
				s_next.rx_ok = 1'b1;
				s_next.rx_byte = peer_dat;
			end
		end
	end
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end
	assign tx_busy = s_reg.busy;
	assign tx_fail = s_reg.fail;
	assign rx_ok = s_reg.rx_ok;
	assign rx_byte = s_reg.rx_byte;
	assign stb = s_reg.stb;
	assign dat = s_reg.dat;
	assign par = s_reg.par;
	assign nak = s_reg.nak;
endmodule
`default_nettype wire

// [verilog/term_end.sv]
// Terminal end of the session link: activation, answer check with retries, negotiation and clock stop.
`timescale 1ns/10ps
`default_nettype none
module term_end
	import card_session_pkg::*;
#(
	parameter int RST_HOLD = 400,
	parameter int ATR_TMO = 20000
)(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Register port
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// Link
	card_link_if.term lk
);
	if (RST_HOLD < 1 || RST_HOLD > 65535 || ATR_TMO < 16 || ATR_TMO > 65535) $error("Count out of range.");
	typedef enum logic [2:0] {T_OFF, T_RST, T_ATR, T_PPS_TX, T_PPS_RX, T_READY, T_STOP, T_WAKE} tstate_t;
	typedef enum logic [2:0] {P_TS, P_T0, P_IF, P_HIST, P_TCK, P_END} phase_t;
	typedef struct packed {
		tstate_t st;
		phase_t ph;
		logic [4:0] ctrl;
		logic [7:0] pps_req;
		logic vcc, rst_n, clk_run;
		logic [15:0] cnt;
		logic [1:0] bad;
		logic rejected;
		logic [3:0] y, k, hi, cur_t, proto;
		logic [1:0] grp;
		logic need_tck, seen_t, hbad, clk_ok, pps_ok, rxv, go;
		logic [7:0] ax, ta1, go_byte, rxd, rdata;
		logic [2:0] idx;
		logic [3:0][7:0] pps;
	} term_t;
	term_t s_reg, s_next;
	logic tx_busy, rx_ok;
	logic [7:0] rx_b;
	always_comb
	begin
		logic good;
		logic fail;
		good = 1'b0;
		fail = 1'b0;
		s_next = s_reg;
		s_next.go = 1'b0;
		s_next.rdata = 8'h00;
		if (rd)
		begin
			unique case (addr)
				REG_CTRL: s_next.rdata = {3'h0, s_reg.ctrl};
				REG_PPS_REQ: s_next.rdata = s_reg.pps_req;
				REG_DATA: s_next.rdata = s_reg.rxd;
				REG_STATUS: s_next.rdata = {s_reg.st == T_ATR, s_reg.clk_ok, s_reg.pps_ok, tx_busy || s_reg.go,
					s_reg.st == T_STOP, s_reg.rejected, s_reg.rxv, s_reg.st == T_READY};
				REG_TA1: s_next.rdata = s_reg.ta1;
				REG_BAD: s_next.rdata = {6'h00, s_reg.bad};
				default: s_next.rdata = 8'h00;
			endcase
			if (addr == REG_DATA)
				s_next.rxv = 1'b0;
		end
		if (wr && addr == REG_CTRL)
			s_next.ctrl = wdata[4:0] & ~(5'h1 << CTRL_WARM);
		if (wr && addr == REG_PPS_REQ)
			s_next.pps_req = wdata;
		if (wr && addr == REG_DATA && s_reg.st == T_READY && !tx_busy && !s_reg.go)
		begin
			s_next.go = 1'b1;
			s_next.go_byte = wdata;
		end
		if (rx_ok && s_reg.st == T_READY)
		begin
			s_next.rxv = 1'b1;
			s_next.rxd = rx_b;
		end
		unique case (s_reg.st)
			T_OFF:
			begin
				if (s_reg.ctrl[CTRL_ACT] && !s_reg.rejected)
				begin
					s_next.vcc = 1'b1;
					s_next.clk_run = 1'b1;
					s_next.st = T_RST;
					s_next.cnt = 16'(RST_HOLD);
				end
			end
			T_RST:
			begin
				s_next.cnt = s_reg.cnt - 16'h1;
				if (s_reg.cnt == 16'h1)
				begin
					s_next.rst_n = 1'b1;
					s_next.st = T_ATR;
					s_next.cnt = 16'(ATR_TMO);
					s_next.ph = P_TS;
					s_next.need_tck = 1'b0;
					s_next.seen_t = 1'b0;
					s_next.hbad = 1'b0;
					s_next.hi = 4'h0;
					s_next.ta1 = FD_DEFAULT;
					s_next.proto = PROTO_T0;
					s_next.clk_ok = 1'b0;
					s_next.pps_ok = 1'b0;
				end
			end
			T_ATR:
			begin
				s_next.cnt = s_reg.cnt - 16'h1;
				if (s_reg.cnt == 16'h1)
					fail = 1'b1;
				if (rx_ok)
				begin
					s_next.ax = s_reg.ax ^ rx_b;
					unique case (s_reg.ph)
						P_TS:
						begin
							s_next.ph = P_T0;
							s_next.hbad = !(rx_b == TS_DIRECT || rx_b == TS_INVERSE);
						end
						P_T0:
						begin
							s_next.ax = rx_b;
							s_next.y = rx_b[7:4];
							s_next.k = rx_b[3:0];
							s_next.grp = 2'h1;
							s_next.ph = P_IF;
						end
						P_IF:
						begin
							if (s_reg.y[0])
							begin
								s_next.y[0] = 1'b0;
								if (s_reg.grp == 2'h1)
									s_next.ta1 = rx_b;
								if (s_reg.grp == 2'h3 && s_reg.cur_t == PROTO_T15)
									s_next.clk_ok = rx_b[7:6] != 2'h0;
							end
							else if (s_reg.y[1])
								s_next.y[1] = 1'b0;
							else if (s_reg.y[2])
								s_next.y[2] = 1'b0;
							else
							begin
								s_next.y = rx_b[7:4];
								s_next.cur_t = rx_b[3:0];
								s_next.seen_t = 1'b1;
								if (!s_reg.seen_t)
									s_next.proto = rx_b[3:0];
								if (rx_b[3:0] != PROTO_T0)
									s_next.need_tck = 1'b1;
								if (s_reg.grp != 2'h3)
									s_next.grp = s_reg.grp + 2'h1;
							end
						end
						P_HIST:
						begin
							if (s_reg.hi == 4'h0 && rx_b != CAT_COMPACT)
								s_next.hbad = 1'b1;
							if (s_reg.hi == 4'h1 && rx_b[7:4] != TAG_DATA_SERVICE[7:4])
								s_next.hbad = 1'b1;
							s_next.hi = s_reg.hi + 4'h1;
							if (s_reg.hi + 4'h1 == s_reg.k)
								s_next.ph = s_reg.need_tck ? P_TCK : P_END;
						end
						P_TCK: s_next.ph = P_END;
						default: ;
					endcase
					if (s_next.ph == P_IF && s_next.y == 4'h0)
						s_next.ph = (s_next.k != 4'h0) ? P_HIST : (s_next.need_tck ? P_TCK : P_END);
					if (s_next.ph == P_END)
					begin
						good = !s_next.hbad && (!s_next.need_tck || s_next.ax == 8'h00);
						fail = !good;
					end
				end
				if (good)
				begin
					s_next.bad = 2'h0;
					s_next.pps = {PPS_START ^ (PPS0_WITH_PPS1 | {4'h0, s_next.proto}) ^ s_reg.pps_req, s_reg.pps_req,
						PPS0_WITH_PPS1 | {4'h0, s_next.proto}, PPS_START};
					s_next.idx = 3'h0;
					if (s_reg.ctrl[CTRL_PPS] && s_reg.pps_req != FD_DEFAULT
						&& (s_reg.pps_req == FD_512_8 || s_reg.pps_req == FD_512_16)
						&& s_reg.pps_req[7:4] <= s_next.ta1[7:4] && s_reg.pps_req[3:0] <= s_next.ta1[3:0])
						s_next.st = T_PPS_TX;
					else
					begin
						s_next.st = T_READY;
						s_next.cnt = 16'h0;
					end
				end
			end
			T_PPS_TX:
			begin
				if (!tx_busy && !s_reg.go)
				begin
					if (s_reg.idx == 3'h4)
					begin
						s_next.st = T_PPS_RX;
						s_next.idx = 3'h0;
						s_next.cnt = 16'(ATR_TMO);
					end
					else
					begin
						s_next.go = 1'b1;
						s_next.go_byte = s_reg.pps[s_reg.idx[1:0]];
						s_next.idx = s_reg.idx + 3'h1;
					end
				end
			end
			T_PPS_RX:
			begin
				s_next.cnt = s_reg.cnt - 16'h1;
				if (s_reg.cnt == 16'h1 || (rx_ok && rx_b != s_reg.pps[s_reg.idx[1:0]]))
				begin
					s_next.st = T_RST;
					s_next.rst_n = 1'b0;
					s_next.cnt = 16'(RST_HOLD);
				end
				else if (rx_ok)
				begin
					s_next.idx = s_reg.idx + 3'h1;
					if (s_reg.idx == 3'h3)
					begin
						s_next.pps_ok = 1'b1;
						s_next.st = T_READY;
						s_next.cnt = 16'h0;
					end
				end
			end
			T_READY:
			begin
				if (rx_ok)
					s_next.cnt = 16'h0;
				else if (s_reg.cnt != 16'hFFFF)
					s_next.cnt = s_reg.cnt + 16'h1;
				if (s_reg.ctrl[CTRL_STOP] && s_reg.clk_ok && !tx_busy && !s_reg.go && !rx_ok
					&& s_reg.cnt >= 16'(CLK_STOP_WAIT - 1))
				begin
					s_next.st = T_STOP;
					s_next.clk_run = 1'b0;
				end
			end
			T_STOP:
			begin
				if (!s_reg.ctrl[CTRL_STOP])
				begin
					s_next.clk_run = 1'b1;
					s_next.st = T_WAKE;
					s_next.cnt = 16'h1;
				end
			end
			T_WAKE:
			begin
				s_next.cnt = s_reg.cnt + 16'h1;
				if (s_reg.cnt == 16'(CLK_RESTART_WAIT))
				begin
					s_next.st = T_READY;
					s_next.cnt = 16'h0;
				end
			end
		endcase
		if (fail)
		begin
			s_next.bad = s_reg.bad + 2'h1;
			s_next.rst_n = 1'b0;
			s_next.cnt = 16'(RST_HOLD);
			s_next.st = T_RST;
			if (s_reg.bad + 2'h1 == BAD_ATR_LIMIT)
			begin
				s_next.rejected = 1'b1;
				s_next.st = T_OFF;
				s_next.vcc = 1'b0;
				s_next.clk_run = 1'b0;
			end
		end
		if (wr && addr == REG_CTRL && wdata[CTRL_WARM] && s_reg.vcc && s_reg.st != T_RST)
		begin
			s_next.st = T_RST;
			s_next.rst_n = 1'b0;
			s_next.clk_run = 1'b1;
			s_next.cnt = 16'(RST_HOLD);
		end
		if (!s_next.ctrl[CTRL_ACT])
		begin
			s_next.st = T_OFF;
			s_next.vcc = 1'b0;
			s_next.rst_n = 1'b0;
			s_next.clk_run = 1'b0;
			s_next.bad = 2'h0;
			s_next.rejected = 1'b0;
		end
	end
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			s_reg <= '0;
			s_reg.st <= T_OFF;
			s_reg.ph <= P_TS;
			s_reg.ctrl <= CTRL_RESET;
			s_reg.pps_req <= PPS_REQ_RESET;
			s_reg.ta1 <= FD_DEFAULT;
		end
		else
			s_reg <= s_next;
	end
	char_port #(
		.MAX_REPEAT(4)
	) u_port (
		.mclk(mclk),
		.reset_n(reset_n),
		.chk_en(s_reg.st != T_ATR || s_reg.ctrl[CTRL_ATRCHK]),
		.tx_go(s_reg.go),
		.tx_byte(s_reg.go_byte),
		.tx_busy(tx_busy),
		.tx_fail(),
		.rx_ok(rx_ok),
		.rx_byte(rx_b),
		.stb(lk.t2c_stb),
		.dat(lk.t2c_dat),
		.par(lk.t2c_par),
		.nak(lk.t2c_nak),
		.peer_stb(lk.c2t_stb),
		.peer_dat(lk.c2t_dat),
		.peer_par(lk.c2t_par),
		.peer_nak(lk.c2t_nak)
	);
	assign rdata = s_reg.rdata;
	assign lk.vcc_on = s_reg.vcc;
	assign lk.rst_pin_n = s_reg.rst_n;
	assign lk.clk_run = s_reg.clk_run;
endmodule
`default_nettype wire
